/* hw/ccb_bank.sv */
/*
 Calibration control and status register bank with sequencer and result registers.
 Assumes a single-cycle strobe master on SYS_CLK and an analog engine answering each step.
*/
// How it works
// - Pulse width register reads pulse code minus off code minus 4, in 61.035 ns.
// - Minimum off time is off code plus 4 steps; off code is 5 bits.
// - Writing one to bit 6 starts whole-system calibration.
// - Bit 6 reads one while whole-system calibration is pending or runs, zero otherwise.
// - Speedup bit picks 300 ms or 30 ms battery settling before whole-system calibration.
// - Each calibration bit reads one while enabled or running, zero when done.
// - Bit 2 of register one enables and reports differential gain calibration.
// - Bits 1 and 0 enable and report common-mode and current-limit calibration.
// - Bit 4 of register two enables and reports monitor converter one calibration.
// - Bit 3 of register two enables and reports monitor converter two calibration.
// - Writing one to bit 2 of register two starts voice output offset calibration.
// - Writing one to bit 1 of register two starts voice input offset calibration.
// - Ring mismatch result is 5-bit read/write, reset 0x10.
// - Tip mismatch result is 5-bit read/write, reset 0x10.
// - Differential gain result is 5-bit read/write.
`timescale 1ns/1ps
`include "ccb_map.svh"
module ccb_bank #(
	parameter int SETTLE_LONG_CYC  = `CCB_SETTLE_LONG_CYC,
	parameter int SETTLE_SHORT_CYC = `CCB_SETTLE_SHORT_CYC,
	parameter int STEP_CYC         = `CCB_STEP_CYC_DEF
) (
	input  wire logic       SYS_CLK,
	input  wire logic       RESET,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	input  wire logic [4:0] CAL_RING_VALUE,
	input  wire logic [4:0] CAL_TIP_VALUE,
	input  wire logic [4:0] CAL_DIFF_VALUE,
	output logic      [7:0] RDATA,
	output logic      [8:0] CAL_ACTIVE,
	output logic            CAL_BUSY
);
	localparam logic [3:0] LAST_STEP = 4'h8;

	ccb_pkg::ccb_req_t    req;
	ccb_pkg::ccb_state_t  state_r;
	ccb_pkg::ccb_state_t  state_nxt;
	ccb_pkg::ccb_result_t res_r;
	ccb_pkg::ccb_result_t res_nxt;
	logic [6:0]  one_r;
	logic [6:0]  one_nxt;
	logic [4:1]  two_r;
	logic [4:1]  two_nxt;
	logic [4:0]  off_code_r;
	logic [4:0]  off_code_nxt;
	logic [7:0]  pw_code_r;
	logic [7:0]  pw_code_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [3:0]  step_r;
	logic [3:0]  step_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic [8:0]  active_r;
	logic [8:0]  active_nxt;
	logic        busy_r;
	logic        busy_nxt;
	logic [7:0]  pulse_steps;
	logic        whole_r;
	logic        whole_nxt;
	logic        wr_one;
	logic        wr_two;
	logic [8:0]  pend;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Maps sequencer step s to CAL_ACTIVE bit s: steps 0..4 are one[0..4], steps 5..8 are two[1..4]
	function automatic logic [8:0] step_mask(input logic [3:0] s);
		step_mask = 9'h001 << s;
	endfunction : step_mask

	ccb_pulse_common_mode_gain_cal u_pulse (
		.clk         (SYS_CLK),
		.rst         (RESET),
		.pw_code     (pw_code_r),
		.off_code    (off_code_r),
		.pulse_steps (pulse_steps),
		.off_steps   ()
	);

	assign wr_one = req.wr && hit(req.addr, `CCB_OFF_CAL_ONE);
	assign wr_two = req.wr && hit(req.addr, `CCB_OFF_CAL_TWO);

	// Pending set: step order ilim, cmode, diff, tip, ring, vin, vout, mon2, mon1
	assign pend = {two_r[4], two_r[3], two_r[2], two_r[1],
		one_r[4], one_r[3], one_r[2], one_r[1], one_r[0]};

	always_comb begin
		state_nxt    = state_r;
		one_nxt      = one_r;
		two_nxt      = two_r;
		res_nxt      = res_r;
		off_code_nxt = off_code_r;
		pw_code_nxt  = pw_code_r;
		cnt_nxt      = cnt_r;
		step_nxt     = step_r;
		whole_nxt    = whole_r;
		if (req.wr && hit(req.addr, `CCB_OFF_RING_RESULT)) begin
			res_nxt.ring = req.wdata[4:0];
		end
		if (req.wr && hit(req.addr, `CCB_OFF_TIP_RESULT)) begin
			res_nxt.tip = req.wdata[4:0];
		end
		if (req.wr && hit(req.addr, `CCB_OFF_DIFF_RESULT)) begin
			res_nxt.diff = req.wdata[4:0];
		end
		if (req.wr && hit(req.addr, `CCB_OFF_OFF_TIME)) begin
			off_code_nxt = req.wdata[4:0];
		end
		if (req.wr && hit(req.addr, `CCB_OFF_PW_CODE)) begin
			pw_code_nxt = req.wdata;
		end
		case (state_r)
			ccb_pkg::CCB_IDLE: begin
				cnt_nxt  = 32'h0;
				step_nxt = 4'h0;
				if (one_r[`CCB_BIT_WHOLE]) begin
					// Whole-system run enables every individual calibration
					one_nxt[4:0] = 5'h1f;
					two_nxt      = 4'hf;
					whole_nxt    = 1'b1;
					state_nxt    = ccb_pkg::CCB_SETTLE;
				end else if (pend != 9'h000) begin
					state_nxt = ccb_pkg::CCB_STEPS;
				end
			end
			ccb_pkg::CCB_SETTLE: begin
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r >= (one_r[`CCB_BIT_SPEEDUP] ?
					32'(SETTLE_SHORT_CYC - 1) : 32'(SETTLE_LONG_CYC - 1))) begin
					cnt_nxt   = 32'h0;
					state_nxt = ccb_pkg::CCB_STEPS;
				end
			end
			ccb_pkg::CCB_STEPS: begin
				if (!pend[step_r]) begin
					cnt_nxt = 32'h0;
					if (step_r == LAST_STEP) begin
						state_nxt = ccb_pkg::CCB_IDLE;
						// A whole run asked for during a single run is kept for the next pass
						if (whole_r) begin
							one_nxt[`CCB_BIT_WHOLE] = 1'b0;
							whole_nxt = 1'b0;
						end
					end else begin
						step_nxt = step_r + 4'h1;
					end
				end else if (cnt_r >= 32'(STEP_CYC - 1)) begin
					cnt_nxt = 32'h0;
					// Step done: clear its bit; diff, tip and ring steps also latch their result
					case (step_r)
						4'h0: one_nxt[`CCB_BIT_ILIM] = 1'b0;
						4'h1: one_nxt[`CCB_BIT_CMODE] = 1'b0;
						4'h2: begin
							one_nxt[`CCB_BIT_DIFF] = 1'b0;
							res_nxt.diff = CAL_DIFF_VALUE;
						end
						4'h3: begin
							one_nxt[`CCB_BIT_TIP] = 1'b0;
							res_nxt.tip = CAL_TIP_VALUE;
						end
						4'h4: begin
							one_nxt[`CCB_BIT_RING] = 1'b0;
							res_nxt.ring = CAL_RING_VALUE;
						end
						4'h5: two_nxt[`CCB_BIT_VIN] = 1'b0;
						4'h6: two_nxt[`CCB_BIT_VOUT] = 1'b0;
						4'h7: two_nxt[`CCB_BIT_MON2] = 1'b0;
						4'h8: two_nxt[`CCB_BIT_MON1] = 1'b0;
						default: step_nxt = 4'h0;
					endcase
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			default: state_nxt = ccb_pkg::CCB_IDLE;
		endcase
		// Applied after the engine, so a write meeting a step completion still sets its bit
		if (wr_one) begin
			one_nxt = one_nxt | req.wdata[6:0];
			one_nxt[`CCB_BIT_SPEEDUP] = req.wdata[`CCB_BIT_SPEEDUP];
		end
		if (wr_two) begin
			two_nxt = two_nxt | req.wdata[4:1];
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (req.rd) begin
			case (req.addr)
				`CCB_OFF_PULSE_WIDTH: rdata_nxt = pulse_steps;
				`CCB_OFF_CAL_ONE:     rdata_nxt = {1'b0, one_r};
				`CCB_OFF_CAL_TWO:     rdata_nxt = {3'h0, two_r, 1'b0};
				`CCB_OFF_RING_RESULT: rdata_nxt = {3'h0, res_r.ring};
				`CCB_OFF_TIP_RESULT:  rdata_nxt = {3'h0, res_r.tip};
				`CCB_OFF_DIFF_RESULT: rdata_nxt = {3'h0, res_r.diff};
				`CCB_OFF_OFF_TIME:    rdata_nxt = {3'h0, off_code_r};
				`CCB_OFF_PW_CODE:     rdata_nxt = pw_code_r;
				default:              rdata_nxt = 8'h00;
			endcase
		end
		active_nxt = 9'h000;
		if (state_nxt == ccb_pkg::CCB_STEPS && pend[step_nxt]) begin
			active_nxt = step_mask(step_nxt);
		end
		busy_nxt = (state_nxt != ccb_pkg::CCB_IDLE);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			state_r    <= ccb_pkg::CCB_IDLE;
			one_r      <= 7'h00;
			two_r      <= 4'h0;
			res_r      <= '{ring: `CCB_RST_MISMATCH, tip: `CCB_RST_MISMATCH,
				diff: `CCB_RST_DIFF};
			off_code_r <= `CCB_RST_OFF_TIME;
			pw_code_r  <= `CCB_RST_PW_CODE;
			cnt_r      <= 32'h0;
			step_r     <= 4'h0;
			rdata_r    <= 8'h00;
			active_r   <= 9'h000;
			busy_r     <= 1'b0;
			whole_r    <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			one_r      <= one_nxt;
			two_r      <= two_nxt;
			res_r      <= res_nxt;
			off_code_r <= off_code_nxt;
			pw_code_r  <= pw_code_nxt;
			cnt_r      <= cnt_nxt;
			step_r     <= step_nxt;
			rdata_r    <= rdata_nxt;
			active_r   <= active_nxt;
			busy_r     <= busy_nxt;
			whole_r    <= whole_nxt;
		end
	end

	assign RDATA      = rdata_r;
	assign CAL_ACTIVE = active_r;
	assign CAL_BUSY   = busy_r;
endmodule : ccb_bank

/* hw/ccb_map.svh */
/*
 Register offsets, field positions, reset values and timing counts of the calibration control bank.
 Assumes inclusion by bare name from the bank and pulse modules.
*/
`ifndef CCB_MAP_SVH
`define CCB_MAP_SVH
`define CCB_OFF_PULSE_WIDTH   8'h5e
`define CCB_OFF_CAL_ONE       8'h60
`define CCB_OFF_CAL_TWO       8'h61
`define CCB_OFF_RING_RESULT   8'h62
`define CCB_OFF_TIP_RESULT    8'h63
`define CCB_OFF_DIFF_RESULT   8'h64
`define CCB_OFF_OFF_TIME      8'h65
`define CCB_OFF_PW_CODE       8'h66
`define CCB_BIT_WHOLE         6
`define CCB_BIT_SPEEDUP       5
`define CCB_BIT_RING          4
`define CCB_BIT_TIP           3
`define CCB_BIT_DIFF          2
`define CCB_BIT_CMODE         1
`define CCB_BIT_ILIM          0
`define CCB_BIT_MON1          4
`define CCB_BIT_MON2          3
`define CCB_BIT_VOUT          2
`define CCB_BIT_VIN           1
`define CCB_RST_MISMATCH      5'h10
`define CCB_RST_DIFF          5'h10
`define CCB_RST_OFF_TIME      5'h14
`define CCB_RST_PW_CODE       8'hff
`define CCB_OFF_TIME_BIAS     8'h04
`define CCB_STEP_PS           61035
`define CCB_SETTLE_LONG_MS    300
`define CCB_SETTLE_SHORT_MS   30
`define CCB_CLK_NS            10
`define CCB_SETTLE_LONG_CYC   (`CCB_SETTLE_LONG_MS * 1000000 / `CCB_CLK_NS)
`define CCB_SETTLE_SHORT_CYC  (`CCB_SETTLE_SHORT_MS * 1000000 / `CCB_CLK_NS)
`define CCB_STEP_CYC_DEF      16
`endif

/* hw/ccb_pkg.sv */
/*
 Types of the calibration control bank.
 Assumes ccb_map.svh is on the include path.
*/
package ccb_pkg;
	typedef enum logic [1:0] {
		CCB_IDLE   = 2'b00,
		CCB_SETTLE = 2'b01,
		CCB_STEPS  = 2'b10
	} ccb_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ccb_req_t;

	typedef struct packed {
		logic [4:0] ring;
		logic [4:0] tip;
		logic [4:0] diff;
	} ccb_result_t;
endpackage : ccb_pkg

/* hw/ccb_pulse_common_mode_gain_cal.sv */
/*
 Derives the regulator drive pulse width and minimum off time in 61.035 ns steps.
 Assumes codes come from registers on the same clock.
*/
`timescale 1ns/1ps
`include "ccb_map.svh"
module ccb_pulse_common_mode_gain_cal (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] pw_code,
	input  wire logic [4:0] off_code,
	output logic      [7:0] pulse_steps,
	output logic      [7:0] off_steps
);
	logic [7:0] pulse_r;
	logic [7:0] pulse_nxt;
	logic [7:0] off_r;
	logic [7:0] off_nxt;

	// Wraps modulo 256 when codes are inconsistent; software must keep pw above off + 4
	// Pulse is the period code less the whole off time, so both share one adder
	always_comb begin
		off_nxt   = {3'h0, off_code} + `CCB_OFF_TIME_BIAS;
		pulse_nxt = pw_code - off_nxt;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pulse_r <= 8'h00;
			off_r   <= 8'h00;
		end else begin
			pulse_r <= pulse_nxt;
			off_r   <= off_nxt;
		end
	end

	assign pulse_steps = pulse_r;
	assign off_steps   = off_r;
endmodule : ccb_pulse_common_mode_gain_cal

/* sim/ccb_bank_monitor.sv */
/*
 Port checker for the calibration control bank.
 Assumes single-cycle strobes and read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
module ccb_bank_monitor #(
	parameter int SETTLE_LONG_CYC  = 20,
	parameter int SETTLE_SHORT_CYC = 5,
	parameter int STEP_CYC         = 8
) (
	input wire logic       SYS_CLK,
	input wire logic       RESET,
	input wire logic [7:0] ADDR,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] WDATA,
	input wire logic [7:0] RDATA,
	input wire logic [8:0] CAL_ACTIVE,
	input wire logic       CAL_BUSY
);
	// Slack covers turn-around between steps
	localparam int BUSY_MAX = SETTLE_LONG_CYC + 9 * STEP_CYC + 32;
	logic [31:0] busy_cnt_r;
	logic [31:0] busy_cnt_nxt;
	always_comb busy_cnt_nxt = CAL_BUSY ? busy_cnt_r + 32'h1 : 32'h0;
	always_ff @(posedge SYS_CLK) busy_cnt_r <= RESET ? 32'h0 : busy_cnt_nxt;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	a_ctl1_rsvd: assert property (
		$past(RD) && $past(ADDR) == 8'h60 |-> !RDATA[7]) else $error("ctrl one bit 7 set");
	a_ctl2_rsvd: assert property (
		$past(RD) && $past(ADDR) == 8'h61 |-> RDATA[7:5] == 3'h0 && !RDATA[0])
		else $error("ctrl two reserved bits set");
	a_result_rsvd: assert property (
		$past(RD) && $past(ADDR) inside {8'h62, 8'h63, 8'h64} |-> RDATA[7:5] == 3'h0)
		else $error("result reserved bits set");
	a_unmapped_zero: assert property (
		$past(RD) && ($past(ADDR) < 8'h5e || $past(ADDR) == 8'h5f || $past(ADDR) > 8'h66)
		|-> RDATA == 8'h00) else $error("unmapped read nonzero");
	a_active_onehot: assert property ($onehot0(CAL_ACTIVE))
		else $error("two steps active");
	a_active_busy: assert property (CAL_ACTIVE != 9'h000 |-> CAL_BUSY)
		else $error("step active while idle");
	a_start_busy: assert property (
		WR && ADDR == 8'h60 && WDATA[6] && !CAL_BUSY |-> ##[1:4] CAL_BUSY)
		else $error("whole calibration did not start");
	a_busy_cause: assert property (
		$rose(CAL_BUSY) |-> $past(WR) || $past(WR, 2) || $past(WR, 3) || $past(WR, 4) ||
		$past(CAL_BUSY, 2))
		else $error("busy without a write");
	a_busy_bounded: assert property (busy_cnt_r <= BUSY_MAX)
		else $error("calibration never finished");
	a_done_idle: assert property ($fell(CAL_BUSY) |-> CAL_ACTIVE == 9'h000)
		else $error("step left active at finish");
	cover property ($rose(CAL_BUSY));
	cover property (CAL_ACTIVE[8]);
	cover property ($past(RD) && $past(ADDR) == 8'h5e);
endmodule : ccb_bank_monitor
bind ccb_bank ccb_bank_monitor #(.SETTLE_LONG_CYC(SETTLE_LONG_CYC),
	.SETTLE_SHORT_CYC(SETTLE_SHORT_CYC), .STEP_CYC(STEP_CYC)) u_mon (.SYS_CLK(SYS_CLK),
	.RESET(RESET), .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
	.CAL_ACTIVE(CAL_ACTIVE), .CAL_BUSY(CAL_BUSY));

/* sim/test_ccb_bank.sv */
/*
 Self-checking bench for the calibration control bank.
 Assumes short settle and step counts set at the instance.
*/
`timescale 1ns/1ps
module test_ccb_bank;
	logic              SYS_CLK = 1'b0;
	logic              RESET = 1'b1;
	ccb_pkg::ccb_req_t req = '0;
	logic [7:0]        RDATA;
	logic [7:0]        d;
	logic [4:0]        ring = 5'h0b;
	logic [4:0]        tip = 5'h16;
	logic [4:0]        dif = 5'h07;
	logic [8:0]        CAL_ACTIVE;
	logic              CAL_BUSY;
	int                n_mismatch = 0;
	int                comparisons = 0;
	int                i;
	int                nl;
	int                ns;
	logic [23:0]       rows [6] = '{24'h5eaae7, 24'h62ff1f, 24'h63ea0a, 24'h643515,
		24'h61e100, 24'h70ff00};
	logic [15:0]       rst_rows [6] = '{16'h6210, 16'h6310, 16'h6410, 16'h6000, 16'h6100,
		16'h5ee7};
	always #5 SYS_CLK = ~SYS_CLK;
	ccb_bank #(.SETTLE_LONG_CYC(20), .SETTLE_SHORT_CYC(5), .STEP_CYC(8)) DUT (.SYS_CLK(SYS_CLK),
		.RESET(RESET), .ADDR(req.addr), .WDATA(req.wdata), .WR(req.wr), .RD(req.rd),
		.CAL_RING_VALUE(ring), .CAL_TIP_VALUE(tip), .CAL_DIFF_VALUE(dif), .RDATA(RDATA),
		.CAL_ACTIVE(CAL_ACTIVE), .CAL_BUSY(CAL_BUSY));
	task automatic chk(input logic [8:0] s, input logic [8:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Write or read; read data lands in d
	task automatic bus(input logic [7:0] a, input logic [7:0] v, input logic w);
		@(posedge SYS_CLK);
		req <= '{a, v, w, !w};
		@(posedge SYS_CLK);
		req <= '{a, v, 1'b0, 1'b0};
		@(posedge SYS_CLK);
		d = RDATA;
	endtask : bus
	task automatic idle;
		for (i = 0; i < 300 && CAL_BUSY !== 1'b0; i++) @(posedge SYS_CLK);
	endtask : idle
	task automatic run_cal(input logic [7:0] a, input int b, input int x);
		bus(a, 8'h01 << b, 1'b1);
		bus(a, 8'h00, 1'b0);
		chk({8'h00, d[b]}, 9'h001);
		for (i = 0; i < 30 && CAL_ACTIVE === 9'h000; i++) @(posedge SYS_CLK);
		chk(CAL_ACTIVE, 9'h001 << x);
		chk({8'h00, CAL_BUSY}, 9'h001);
		idle();
		bus(a, 8'h00, 1'b0);
		chk({1'b0, d}, 9'h000);
	endtask : run_cal
	// Cycles spent busy before the first step, a measure of settling
	task automatic settle(input logic [7:0] v, output int n);
		bus(8'h60, v, 1'b1);
		n = 0;
		for (i = 0; i < 200 && CAL_ACTIVE === 9'h000; i++) begin
			@(posedge SYS_CLK);
			n += int'(CAL_BUSY === 1'b1);
		end
	endtask : settle
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	initial begin
		repeat (5000) @(posedge SYS_CLK);
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge SYS_CLK);
		RESET <= 1'b0;
		foreach (rows[k]) begin
			bus(rows[k][23:16], rows[k][15:8], 1'b1);
			bus(rows[k][23:16], 8'h00, 1'b0);
			chk({1'b0, d}, {1'b0, rows[k][7:0]});
		end
		run_cal(8'h60, 4, 4);
		run_cal(8'h60, 3, 3);
		run_cal(8'h60, 2, 2);
		run_cal(8'h60, 1, 1);
		run_cal(8'h60, 0, 0);
		run_cal(8'h61, 4, 8);
		run_cal(8'h61, 3, 7);
		run_cal(8'h61, 2, 6);
		run_cal(8'h61, 1, 5);
		bus(8'h62, 8'h00, 1'b0);
		chk({1'b0, d}, {4'h0, ring});
		bus(8'h63, 8'h00, 1'b0);
		chk({1'b0, d}, {4'h0, tip});
		dif <= 5'h19;
		settle(8'h40, nl);
		// A zero write must not abort the run
		bus(8'h60, 8'h00, 1'b1);
		bus(8'h60, 8'h00, 1'b0);
		chk({8'h00, d[6]}, 9'h001);
		idle();
		bus(8'h60, 8'h00, 1'b0);
		chk({1'b0, d}, 9'h000);
		bus(8'h64, 8'h00, 1'b0);
		chk({1'b0, d}, 9'h019);
		settle(8'h60, ns);
		idle();
		bus(8'h60, 8'h00, 1'b0);
		chk({1'b0, d}, 9'h020);
		chk(9'(nl - ns), 9'h00f);
		bus(8'h60, 8'h40, 1'b1);
		repeat (30) @(posedge SYS_CLK);
		RESET <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		RESET <= 1'b0;
		@(posedge SYS_CLK);
		chk(CAL_ACTIVE, 9'h000);
		chk({8'h00, CAL_BUSY}, 9'h000);
		foreach (rst_rows[k]) begin
			bus(rst_rows[k][15:8], 8'h00, 1'b0);
			chk({1'b0, d}, {1'b0, rst_rows[k][7:0]});
		end
		bus(8'h65, 8'h3f, 1'b1);
		bus(8'h66, 8'h80, 1'b1);
		repeat (4) @(posedge SYS_CLK);
		bus(8'h5e, 8'h00, 1'b0);
		chk({1'b0, d}, 9'h05d);
		stop_test();
	end
endmodule : test_ccb_bank
